// file: rtl/timer3_pkg.sv
// Constants, register map and field layout of the 16-bit capture/reload/baud timer.
package timer3_pkg;

   // ==========================================================================
   // Register addresses on the special function register port.
   // ==========================================================================
   localparam logic [7:0] ADDR_CONTROL      = 8'h00_C8; // Timer control and flags.
   localparam logic [7:0] ADDR_RELOAD_LOW   = 8'h00_CA; // Capture/reload low byte.
   localparam logic [7:0] ADDR_RELOAD_HIGH  = 8'h00_CB; // Capture/reload high byte.
   localparam logic [7:0] ADDR_COUNT_LOW    = 8'h00_CC; // Count low byte.
   localparam logic [7:0] ADDR_COUNT_HIGH   = 8'h00_CD; // Count high byte.

   // ==========================================================================
   // Bit positions in the control register.
   // ==========================================================================
   localparam int BIT_OVERFLOW   = 7; // Overflow flag.
   localparam int BIT_EXTERNAL   = 6; // External event flag.
   localparam int BIT_RX_SELECT  = 5; // Receive clock select.
   localparam int BIT_TX_SELECT  = 4; // Transmit clock select.
   localparam int BIT_EXT_ENABLE = 3; // External trigger enable.
   localparam int BIT_RUN        = 2; // Run control.
   localparam int BIT_COUNTER    = 1; // Counter/timer select.
   localparam int BIT_CAPTURE    = 0; // Capture/reload select.

   // ==========================================================================
   // Reset values.
   // ==========================================================================
   localparam logic [7:0]  CONTROL_RESET = 8'h00_00; // All control bits cleared.
   localparam logic [15:0] COUNT_RESET   = 16'h0000; // Count cleared.
   localparam logic [15:0] RELOAD_RESET  = 16'h0000; // Reload pair cleared.
   localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF; // Value that overflows.
   localparam logic [7:0]  READ_UNMAPPED = 8'h00_00; // Answer to other addresses.

   // ==========================================================================
   // Prescaler: CPU clocks per increment.
   // ==========================================================================
   localparam int         CLOCKS_PER_TICK_BAUD = 2;  // Baud generator time base.
   localparam int         CLOCKS_PER_TICK_FAST = 4;  // Rate bit set.
   localparam int         CLOCKS_PER_TICK_SLOW = 12; // Rate bit clear.
   localparam logic [3:0] PRESCALE_LAST = 4'(CLOCKS_PER_TICK_SLOW - 1); // Wrap value.

   // Increment source selected by the mode bits.
   typedef enum logic [1:0] {
      TICK_SLOW = 2'b00, // Every twelve clocks.
      TICK_FAST = 2'b01, // Every four clocks.
      TICK_BAUD = 2'b10, // Every two clocks.
      TICK_PIN  = 2'b11  // Falling edge on the count pin.
   } tick_source_t;

endpackage : timer3_pkg

// file: rtl/pin_event_if.sv
// Carrier for the synchronised pin edge events between the timer modules.
`timescale 1ns/1ps
interface pin_event_if;
   logic trigger_fall; // One-cycle pulse: falling edge on the trigger pin.
   logic count_fall;   // One-cycle pulse: falling edge on the count pin.

   // The synchroniser drives the events.
   modport producer (output trigger_fall, output count_fall);
   // The timer core consumes them.
   modport consumer (input trigger_fall, input count_fall);
endinterface : pin_event_if

// file: rtl/pin_edge_sync.sv
// Two-flop synchroniser and falling edge detector for the trigger and count pins.
`timescale 1ns/1ps
module pin_edge_sync (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic [1:0]  pins,
   pin_event_if.producer    events
);
   import timer3_pkg::*;

   // ==========================================================================
   // Synchroniser chain, one per pin.
   // ==========================================================================
   logic [1:0] sync_first;  // First stage, read only by the second stage.
   logic [1:0] sync_second; // Second stage, safe to use.
   logic [1:0] sample_prev; // Registered previous safe sample.
   logic [1:0] fall;        // Registered high followed by low sample.

   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : g_pin
         // Pins idle high so a reset does not invent an edge.
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               sync_first[i]  <= 1'b1;
               sync_second[i] <= 1'b1;
               sample_prev[i] <= 1'b1;
            end else if (ce) begin
               sync_first[i]  <= pins[i];
               sync_second[i] <= sync_first[i];
               sample_prev[i] <= sync_second[i];
            end
         end
         // A falling edge is a registered high sample followed by a low one.
         assign fall[i] = sample_prev[i] & ~sync_second[i];
      end
   endgenerate

   // Bit 0 is the trigger pin, bit 1 the count pin.
   assign events.trigger_fall = fall[0];
   assign events.count_fall   = fall[1];

endmodule : pin_edge_sync

// file: rtl/timer3_top.sv
// Sixteen-bit timer/counter with capture, auto-reload and baud generation.
`timescale 1ns/1ps
module timer3_top (
   input  wire logic       MCLK_IN,          // CPU clock, 100 MHz.
   input  wire logic       RESETN_IN,        // Synchronous active-low reset.
   input  wire logic       CE_IN,            // Clock enable, freezes all state when low.
   input  wire logic [7:0] SFR_ADDR_IN,      // Register address.
   input  wire logic [7:0] SFR_WDATA_IN,     // Write data.
   input  wire logic       SFR_WE_IN,        // Write strobe.
   output logic      [7:0] SFR_RDATA_OUT,    // Registered read data.
   input  wire logic       RATE_SELECT_IN,   // Rate select bit of the clock control register.
   input  wire logic       TRIGGER_PIN_IN,   // External trigger pin.
   input  wire logic       COUNT_PIN_IN,     // External count pin.
   input  wire logic       TIMER1_OVF_IN,    // Timer 1 overflow pulse.
   output logic            TIMER_IRQ_OUT,    // Timer interrupt request level.
   output logic            RX_SHIFT_CLK_OUT, // Receive shift clock to the serial port.
   output logic            TX_SHIFT_CLK_OUT  // Transmit shift clock to the serial port.
);
   import timer3_pkg::*;

   // ==========================================================================
   // Registers and mode decode.
   // ==========================================================================
   logic [7:0]   control;      // Control and flag register.
   logic [15:0]  count;        // The sixteen-bit count.
   logic [15:0]  reload;       // Capture/reload pair.
   logic [3:0]   prescale;     // Free-running divide-by-twelve counter.
   logic         ovf_pulse;    // Registered overflow pulse.
   logic         baud_mode;    // Either serial clock select is set.
   logic         run;          // Run control bit.
   logic         ext_enable;   // External trigger enable bit.
   logic         capture_mode; // Capture selected and not in baud mode.
   logic         increment;    // Count advances this cycle.
   logic         overflow;     // Count wraps this cycle.
   logic         trig_capture; // Trigger edge copies the count.
   logic         trig_reload;  // Trigger edge reloads the count.
   logic         ext_event;    // Trigger edge sets the external flag.
   logic         ctrl_wr;      // Write to the control register.
   tick_source_t source;       // Selected increment source.
   logic [15:0]  next_count;   // Count after this cycle.

   pin_event_if events ();     // Synchronised pin edges.

   // Pin synchroniser and edge detector.
   pin_edge_sync u_sync (
      .clk    (MCLK_IN),
      .rst_n  (RESETN_IN),
      .ce     (CE_IN),
      .pins   ({COUNT_PIN_IN, TRIGGER_PIN_IN}),
      .events (events.producer)
   );

   // Decides whether the prescaler is at a tick for the given source.
   function automatic logic tick_due(input tick_source_t src, input logic [3:0] pre,
                                     input logic pin_fall);
      logic due;
      due = 1'b0;
      unique case (src)
         TICK_SLOW: due = (pre == PRESCALE_LAST);
         TICK_FAST: due = (pre[1:0] == 2'(CLOCKS_PER_TICK_FAST - 1));
         TICK_BAUD: due = (pre[0] == 1'(CLOCKS_PER_TICK_BAUD - 1));
         TICK_PIN:  due = pin_fall;
      endcase
      return due;
   endfunction : tick_due

   assign run          = control[BIT_RUN];
   assign ext_enable   = control[BIT_EXT_ENABLE];
   assign baud_mode    = control[BIT_RX_SELECT] | control[BIT_TX_SELECT];
   // Serial clocking overrides the capture select and forces reload.
   assign capture_mode = control[BIT_CAPTURE] & ~baud_mode;
   assign ctrl_wr      = SFR_WE_IN && (SFR_ADDR_IN == ADDR_CONTROL);

   // Pick the increment source from the mode bits.
   always_comb begin
      if (control[BIT_COUNTER]) begin
         source = TICK_PIN;
      end else if (baud_mode) begin
         source = TICK_BAUD;
      end else if (RATE_SELECT_IN) begin
         source = TICK_FAST;
      end else begin
         source = TICK_SLOW;
      end
   end

   // The run bit gates every increment.
   assign increment = run && tick_due(source, prescale, events.count_fall);
   assign overflow  = increment && (count == COUNT_ALL_ONES);

   // Trigger edges act only with the external enable set; baud mode sets the flag only.
   assign ext_event    = events.trigger_fall && ext_enable;
   assign trig_capture = ext_event && capture_mode;
   assign trig_reload  = ext_event && !capture_mode && !baud_mode;

   // ==========================================================================
   // Prescaler.
   // ==========================================================================
   // Free-running divider shared by all three timer rates.
   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         prescale <= 4'h0;
      end else if (CE_IN) begin
         prescale <= (prescale == PRESCALE_LAST) ? 4'h0 : prescale + 4'h1;
      end
   end

   // ==========================================================================
   // Count.
   // ==========================================================================
   // Reloads on overflow outside capture mode and on trigger; software writes win.
   always_comb begin
      next_count = count;
      if (overflow && !capture_mode) begin
         next_count = reload;
      end else if (trig_reload) begin
         next_count = reload;
      end else if (increment) begin
         next_count = count + 16'h0001;
      end
      if (SFR_WE_IN && SFR_ADDR_IN == ADDR_COUNT_LOW) begin
         next_count[7:0] = SFR_WDATA_IN;
      end
      if (SFR_WE_IN && SFR_ADDR_IN == ADDR_COUNT_HIGH) begin
         next_count[15:8] = SFR_WDATA_IN;
      end
   end

   // Count register.
   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         count <= COUNT_RESET;
      end else if (CE_IN) begin
         count <= next_count;
      end
   end

   // ==========================================================================
   // Capture/reload pair.
   // ==========================================================================
   // A capture wins over a software write in the same cycle.
   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         reload <= RELOAD_RESET;
      end else if (CE_IN) begin
         if (trig_capture) begin
            reload <= count;
         end else if (SFR_WE_IN && SFR_ADDR_IN == ADDR_RELOAD_LOW) begin
            reload[7:0] <= SFR_WDATA_IN;
         end else if (SFR_WE_IN && SFR_ADDR_IN == ADDR_RELOAD_HIGH) begin
            reload[15:8] <= SFR_WDATA_IN;
         end
      end
   end

   // ==========================================================================
   // Control register and flags.
   // ==========================================================================
   // Hardware set wins over a software clear; writing one sets a flag.
   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         control <= CONTROL_RESET;
      end else if (CE_IN) begin
         if (ctrl_wr) begin
            control <= SFR_WDATA_IN;
         end
         if (overflow && !baud_mode) begin
            control[BIT_OVERFLOW] <= 1'b1;
         end
         if (ext_event) begin
            control[BIT_EXTERNAL] <= 1'b1;
         end
      end
   end

   // Either flag raises the request; enabling is the interrupt controller's job.
   assign TIMER_IRQ_OUT = control[BIT_OVERFLOW] | control[BIT_EXTERNAL];

   // ==========================================================================
   // Serial shift clocks.
   // ==========================================================================
   // Overflow pulse registered for the serial port in baud mode.
   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         ovf_pulse <= 1'b0;
      end else if (CE_IN) begin
         ovf_pulse <= overflow && baud_mode;
      end
   end

   // Each select picks this timer's overflow or Timer 1's.
   assign RX_SHIFT_CLK_OUT = control[BIT_RX_SELECT] ? ovf_pulse : TIMER1_OVF_IN;
   assign TX_SHIFT_CLK_OUT = control[BIT_TX_SELECT] ? ovf_pulse : TIMER1_OVF_IN;

   // ==========================================================================
   // Read port.
   // ==========================================================================
   // Read data is registered one cycle after the address.
   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         SFR_RDATA_OUT <= READ_UNMAPPED;
      end else if (CE_IN) begin
         unique case (SFR_ADDR_IN)
            ADDR_CONTROL:     SFR_RDATA_OUT <= control;
            ADDR_RELOAD_LOW:  SFR_RDATA_OUT <= reload[7:0];
            ADDR_RELOAD_HIGH: SFR_RDATA_OUT <= reload[15:8];
            ADDR_COUNT_LOW:   SFR_RDATA_OUT <= count[7:0];
            ADDR_COUNT_HIGH:  SFR_RDATA_OUT <= count[15:8];
            default:          SFR_RDATA_OUT <= READ_UNMAPPED;
         endcase
      end
   end

   // ==========================================================================
   // Assertions.
   // ==========================================================================
   // Overflow outside baud mode sets the overflow flag.
   chk_ovf_sets_flag: assert property (
      @(posedge MCLK_IN) disable iff (!RESETN_IN)
      CE_IN && overflow && !baud_mode |=> control[BIT_OVERFLOW])
      else $error("Overflow did not set the overflow flag.");

   // Baud mode never sets the overflow flag by hardware.
   chk_baud_no_flag: assert property (
      @(posedge MCLK_IN) disable iff (!RESETN_IN)
      CE_IN && baud_mode && !control[BIT_OVERFLOW] && !ctrl_wr |=> !control[BIT_OVERFLOW])
      else $error("Overflow flag set in baud mode.");

   // A software write of one to a flag raises the request next cycle.
   chk_sw_force_irq: assert property (
      @(posedge MCLK_IN) disable iff (!RESETN_IN)
      CE_IN && ctrl_wr && (SFR_WDATA_IN[BIT_OVERFLOW] || SFR_WDATA_IN[BIT_EXTERNAL])
      |=> TIMER_IRQ_OUT)
      else $error("Flag write did not raise the interrupt request.");

   // An enabled trigger edge sets the external flag.
   chk_ext_flag_set: assert property (
      @(posedge MCLK_IN) disable iff (!RESETN_IN)
      CE_IN && events.trigger_fall && ext_enable |=> control[BIT_EXTERNAL])
      else $error("Trigger edge did not set the external flag.");

   // With the enable clear the trigger changes neither flag nor reload pair.
   chk_trig_ignored: assert property (
      @(posedge MCLK_IN) disable iff (!RESETN_IN)
      CE_IN && events.trigger_fall && !ext_enable && !ctrl_wr && !SFR_WE_IN
      |=> $stable(control[BIT_EXTERNAL]) && $stable(reload))
      else $error("Trigger edge acted while disabled.");

   // Capture copies the whole count.
   chk_capture_copy: assert property (
      @(posedge MCLK_IN) disable iff (!RESETN_IN)
      CE_IN && trig_capture |=> reload == $past(count))
      else $error("Capture did not copy the count.");

   // Overflow in reload mode loads the reload pair.
   chk_ovf_reload: assert property (
      @(posedge MCLK_IN) disable iff (!RESETN_IN)
      CE_IN && overflow && !capture_mode && !SFR_WE_IN |=> count == $past(reload))
      else $error("Overflow did not reload the count.");

   // With run clear the count holds unless written or reloaded.
   chk_stopped_holds: assert property (
      @(posedge MCLK_IN) disable iff (!RESETN_IN)
      CE_IN && !run && !SFR_WE_IN && !trig_reload |=> $stable(count))
      else $error("Count moved while stopped.");

   // Baud timer ticks advance the count on every second clock.
   // Only checked once baud counting already ran in the previous enabled cycle,
   // so the cycle in which run is first set cannot trip it.
   chk_baud_rate: assert property (
      @(posedge MCLK_IN) disable iff (!RESETN_IN)
      CE_IN && $past(CE_IN) && source == TICK_BAUD && run
      && $past(source == TICK_BAUD && run) |-> increment != $past(increment))
      else $error("Baud time base is not every second clock.");

   // Own overflow reaches the selected transmit clock.
   chk_tx_select: assert property (
      @(posedge MCLK_IN) disable iff (!RESETN_IN)
      control[BIT_TX_SELECT] && ovf_pulse |-> TX_SHIFT_CLK_OUT)
      else $error("Transmit shift clock missing.");

   // Main scenarios.
   cov_capture:  cover property (@(posedge MCLK_IN) CE_IN && trig_capture);
   cov_reload:   cover property (@(posedge MCLK_IN) CE_IN && overflow && !baud_mode);
   cov_baud_ovf: cover property (@(posedge MCLK_IN) CE_IN && overflow && baud_mode);

endmodule : timer3_top

// file: test/pin_partner.sv
// Model of the trigger and count pins, Timer 1 and the serial port shift clock inputs.
`timescale 1ns/1ps
module pin_partner (
   input  wire logic clk_in,      // CPU clock.
   input  wire logic rx_clk_in,   // Receive shift clock from the timer.
   input  wire logic tx_clk_in,   // Transmit shift clock from the timer.
   output logic      trigger_out, // Trigger pin, idle high.
   output logic      count_out,   // Count pin, idle high.
   output logic      t1_ovf_out   // Timer 1 overflow pulse.
);
   int rx_seen; // Receive shift clocks taken.
   int tx_seen; // Transmit shift clocks taken.
   initial begin
      trigger_out = 1'b1;
      count_out = 1'b1;
      t1_ovf_out = 1'b0;
      rx_seen = 0;
      tx_seen = 0;
   end
   // The serial port counts every shift clock pulse it sees.
   always @(posedge clk_in) begin
      rx_seen <= rx_seen + int'(rx_clk_in);
      tx_seen <= tx_seen + int'(tx_clk_in);
   end
   // One falling edge on a pin; each level is held three cycles so the synchroniser sees it.
   task automatic pin_fall(input bit trig);
      @(posedge clk_in);
      if (trig) begin
         trigger_out <= 1'b0;
      end else begin
         count_out <= 1'b0;
      end
      repeat (3) @(posedge clk_in);
      trigger_out <= 1'b1;
      count_out <= 1'b1;
      repeat (3) @(posedge clk_in);
   endtask : pin_fall
   // One-cycle overflow pulse from Timer 1.
   task automatic t1_pulse();
      @(posedge clk_in);
      t1_ovf_out <= 1'b1;
      @(posedge clk_in);
      t1_ovf_out <= 1'b0;
      repeat (2) @(posedge clk_in);
   endtask : t1_pulse
endmodule : pin_partner

// file: test/tb_top.sv
// Self-checking bench for the sixteen-bit capture/reload/baud timer.
`timescale 1ns/1ps
module tb_top;
   import timer3_pkg::*;
   logic       mclk;        // CPU clock.
   logic       resetn;      // Active-low reset.
   logic       ce;          // Clock enable.
   logic [7:0] addr;        // Register address.
   logic [7:0] wdata;       // Write data.
   logic       we;          // Write strobe.
   logic       rate;        // Rate select bit.
   logic [7:0] rdata;       // Read data.
   logic       irq;         // Interrupt request.
   logic       rx_clk;      // Receive shift clock.
   logic       tx_clk;      // Transmit shift clock.
   logic       trig;        // Trigger pin.
   logic       cnt;         // Count pin.
   logic       t1_ovf;      // Timer 1 overflow.
   int         mismatches;  // Failed compares.
   int         checks_done; // Compares made.
   int         rx0;         // Receive clocks before a test.
   int         tx0;         // Transmit clocks before a test.
   timer3_top u_timer3_top (.MCLK_IN(mclk), .RESETN_IN(resetn), .CE_IN(ce),
      .SFR_ADDR_IN(addr), .SFR_WDATA_IN(wdata), .SFR_WE_IN(we), .SFR_RDATA_OUT(rdata),
      .RATE_SELECT_IN(rate), .TRIGGER_PIN_IN(trig), .COUNT_PIN_IN(cnt),
      .TIMER1_OVF_IN(t1_ovf), .TIMER_IRQ_OUT(irq), .RX_SHIFT_CLK_OUT(rx_clk),
      .TX_SHIFT_CLK_OUT(tx_clk));
   pin_partner u_pin_partner (.clk_in(mclk), .rx_clk_in(rx_clk), .tx_clk_in(tx_clk),
      .trigger_out(trig), .count_out(cnt), .t1_ovf_out(t1_ovf));
   // ==========================================================================
   // Access tasks.
   // ==========================================================================
   // Compares a seen value with the expected one and counts both.
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Register write, taken at the second edge.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge mclk);
      we <= 1'b0;
   endtask : wr
   // Register read; data stands one edge after the address.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      @(posedge mclk);
      #1;
      d = rdata;
   endtask : rd
   // Reads a byte and compares it.
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      check({8'h00_00, d}, {8'h00_00, exp});
   endtask : rchk
   // Writes a byte pair, low byte first.
   task automatic set16(input logic [7:0] lo, input logic [15:0] v);
      wr(lo, v[7:0]);
      wr(lo + 8'h00_01, v[15:8]);
   endtask : set16
   // Reads a byte pair and compares it.
   task automatic rd16(input logic [7:0] lo, input logic [15:0] exp);
      logic [7:0] l;
      logic [7:0] h;
      rd(lo, l);
      rd(lo + 8'h00_01, h);
      check({h, l}, exp);
   endtask : rd16
   // Runs exactly 120 edges from zero; the tick count does not depend on prescaler phase.
   task automatic run_window(input logic [7:0] ctrl, input logic [15:0] exp);
      set16(ADDR_COUNT_LOW, 16'h0000);
      wr(ADDR_CONTROL, ctrl);
      repeat (118) @(posedge mclk);
      wr(ADDR_CONTROL, ctrl & 8'h00_FB);
      rd16(ADDR_COUNT_LOW, exp);
   endtask : run_window
   // Prints the counts and the verdict, then stops.
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_sim
   // ==========================================================================
   // Clock, watchdog and test sequence.
   // ==========================================================================
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // A hang counts as a mismatch.
   initial begin
      #1_000_000;
      mismatches++;
      end_sim();
   end
   initial begin
      resetn = 1'b0;
      ce = 1'b1;
      addr = 8'h00_00;
      wdata = 8'h00_00;
      we = 1'b0;
      rate = 1'b0;
      mismatches = 0;
      checks_done = 0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      rchk(ADDR_CONTROL, 8'h00_00);
      rd16(ADDR_RELOAD_LOW, 16'h0000);
      rd16(ADDR_COUNT_LOW, 16'h0000);
      wr(8'h00_C9, 8'h00_FF);
      rchk(8'h00_C9, 8'h00_00);
      set16(ADDR_RELOAD_LOW, 16'hA55A);
      set16(ADDR_COUNT_LOW, 16'h3CC3);
      rd16(ADDR_RELOAD_LOW, 16'hA55A);
      rd16(ADDR_COUNT_LOW, 16'h3CC3);
      $display("test registers done");
      wr(ADDR_CONTROL, 8'h00_80);
      #1 check({15'h0000, irq}, 16'h0001);
      wr(ADDR_CONTROL, 8'h00_40);
      #1 check({15'h0000, irq}, 16'h0001);
      wr(ADDR_CONTROL, 8'h00_00);
      #1 check({15'h0000, irq}, 16'h0000);
      $display("test flag writes done");
      run_window(8'h00_04, 16'd10);
      rate <= 1'b1;
      run_window(8'h00_04, 16'd30);
      run_window(8'h00_14, 16'd60);
      repeat (30) @(posedge mclk);
      rd16(ADDR_COUNT_LOW, 16'd60);
      $display("test rates done");
      set16(ADDR_RELOAD_LOW, 16'hFFF0);
      set16(ADDR_COUNT_LOW, 16'hFFFE);
      wr(ADDR_CONTROL, 8'h00_06);
      u_pin_partner.pin_fall(1'b0);
      u_pin_partner.pin_fall(1'b0);
      rd16(ADDR_COUNT_LOW, 16'hFFF0);
      rchk(ADDR_CONTROL, 8'h00_86);
      check({15'h0000, irq}, 16'h0001);
      $display("test counter reload done");
      wr(ADDR_CONTROL, 8'h00_00);
      set16(ADDR_COUNT_LOW, 16'h1234);
      u_pin_partner.pin_fall(1'b1);
      rd16(ADDR_COUNT_LOW, 16'h1234);
      rchk(ADDR_CONTROL, 8'h00_00);
      wr(ADDR_CONTROL, 8'h00_08);
      u_pin_partner.pin_fall(1'b1);
      rd16(ADDR_COUNT_LOW, 16'hFFF0);
      rchk(ADDR_CONTROL, 8'h00_48);
      set16(ADDR_COUNT_LOW, 16'hABCD);
      wr(ADDR_CONTROL, 8'h00_09);
      u_pin_partner.pin_fall(1'b1);
      rd16(ADDR_RELOAD_LOW, 16'hABCD);
      rchk(ADDR_CONTROL, 8'h00_49);
      $display("test trigger done");
      wr(ADDR_CONTROL, 8'h00_00);
      rx0 = u_pin_partner.rx_seen;
      tx0 = u_pin_partner.tx_seen;
      u_pin_partner.t1_pulse();
      check(16'(u_pin_partner.rx_seen - rx0), 16'd1);
      check(16'(u_pin_partner.tx_seen - tx0), 16'd1);
      set16(ADDR_RELOAD_LOW, 16'h0102);
      set16(ADDR_COUNT_LOW, 16'hFFFF);
      wr(ADDR_CONTROL, 8'h00_3E);
      u_pin_partner.pin_fall(1'b0);
      check(16'(u_pin_partner.rx_seen - rx0), 16'd2);
      check(16'(u_pin_partner.tx_seen - tx0), 16'd2);
      rd16(ADDR_COUNT_LOW, 16'h0102);
      rchk(ADDR_CONTROL, 8'h00_3E);
      wr(ADDR_COUNT_LOW, 8'h00_55);
      u_pin_partner.pin_fall(1'b1);
      rd16(ADDR_COUNT_LOW, 16'h0155);
      rchk(ADDR_CONTROL, 8'h00_7E);
      $display("test baud done");
      rx0 = u_pin_partner.rx_seen;
      tx0 = u_pin_partner.tx_seen;
      u_pin_partner.t1_pulse();
      check(16'(u_pin_partner.rx_seen - rx0), 16'd0);
      check(16'(u_pin_partner.tx_seen - tx0), 16'd0);
      // Clock enable low freezes register writes and the pin synchronisers.
      ce <= 1'b0;
      wr(ADDR_COUNT_LOW, 8'h00_99);
      u_pin_partner.pin_fall(1'b0);
      ce <= 1'b1;
      rd16(ADDR_COUNT_LOW, 16'h0155);
      // A reset in mid-run clears the control register, the reload pair and the request.
      resetn <= 1'b0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      rchk(ADDR_CONTROL, 8'h00_00);
      check({15'h0000, irq}, 16'h0000);
      rd16(ADDR_RELOAD_LOW, 16'h0000);
      $display("test freeze and reset done");
      end_sim();
   end
endmodule : tb_top
